// >>> snp_regs.svh
// register offsets, field positions, opcodes and limits of the nand sequencer
`ifndef SNP_REGS_SVH
`define SNP_REGS_SVH
// Functional notes
// - quad load sends data on four lines
// - quad load only with quad_input_enable set
// - execute is opcode plus 24-bit row
// - next load only after program completes
// - wait cache_program_busy zero before continuing
// - last page uses plain execute
// - data move: page read, loads, enable, execute
// - data move writes follow write enable
// - move blocks share parity and half
// - random load: opcode, dummy, 12-bit column
// - new random load per discontiguous column
// - quad random load needs quad_input_enable
// - block erase is opcode plus 24-bit row
// - load: opcode, dummy nibble, column, data
// ==========================================
// register byte offsets
`define SNP_OFS_CTRL 8'h00
`define SNP_OFS_ROW 8'h04
`define SNP_OFS_COL 8'h08
`define SNP_OFS_DATA 8'h0C
`define SNP_OFS_STAT 8'h10
`define SNP_OFS_FEAT 8'h14
// ==========================================
// fields
`define SNP_COL_LSB 0
`define SNP_LEN_LSB 16
`define SNP_FEAT_QIE 0
`define SNP_FEAT_ECC 1
`define SNP_ROW_RST 24'h000000
`define SNP_COL_RST 12'h000
// ==========================================
// device opcodes and feature addresses
`define SNP_OP_WRITE_EN 8'h06
`define SNP_OP_LOAD 8'h02
`define SNP_OP_LOAD4 8'h32
`define SNP_OP_RAND 8'h84
`define SNP_OP_RAND4 8'hC4
`define SNP_OP_EXEC 8'h10
`define SNP_OP_BG_TAIL 8'h15
`define SNP_OP_ERASE 8'hD8
`define SNP_OP_PAGE_RD 8'h13
`define SNP_OP_GET_FEAT 8'h0F
`define SNP_OP_SET_FEAT 8'h1F
`define SNP_FA_CFG 8'hB0
`define SNP_FA_STAT 8'hC0
`define SNP_FA_STAT2 8'hF0
// ==========================================
// device status bits and geometry
`define SNP_ST_BUSY 0
`define SNP_ST_EFAIL 2
`define SNP_ST_PFAIL 3
`define SNP_ST2_CBUSY 1
`define SNP_CFG_QIE 0
`define SNP_CFG_ECC 4
`define SNP_MAX_NOECC 13'd2176
`define SNP_MAX_ECC 13'd2112
`define SNP_BLK_LSB 6
`define SNP_BLK_MSB 17
`endif

// >>> snp_pkg.sv
// types of the nand program/erase sequencer
package snp_pkg;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_LOAD = 4'h1, CMD_LOAD4 = 4'h2, CMD_RAND = 4'h3,
    CMD_RAND4 = 4'h4, CMD_EXEC = 4'h5, CMD_EXEC_BG = 4'h6, CMD_ERASE = 4'h7,
    CMD_PAGE_RD = 4'h8, CMD_SET_FEAT = 4'h9, CMD_GET_STAT = 4'hA
  } snp_cmd_e;
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00, Q_WREN = 2'b01, Q_MAIN = 2'b10, Q_POLL = 2'b11
  } snp_seq_e;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_RUN = 2'b01, E_END = 2'b10, E_GAP = 2'b11
  } snp_eng_e;
  typedef enum logic [1:0] {
    SG_OPC = 2'b00, SG_ADR = 2'b01, SG_DAT = 2'b10, SG_RD = 2'b11
  } snp_seg_e;
endpackage : snp_pkg

// >>> snp_buf_if.sv
// page buffer port between sequencer and its memory
`timescale 1ns/1ps
interface snp_buf_if #(parameter int AW = 12);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : snp_buf_if

// >>> snp_buf.sv
// page buffer memory with registered read data
`timescale 1ns/1ps
module snp_buf #(
  parameter int DEPTH = 2176,
  parameter int AW = 12
) (
  input wire logic clk_i, // system clock
  snp_buf_if.mem bus      // buffer port
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("snp_buf: depth exceeds address range");
  end
  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end
  always_ff @(posedge clk_i) begin
    bus.rdata <= mem[bus.raddr];
  end
endmodule : snp_buf

// >>> snp_ctrl.sv
// spi nand program/erase sequencer with wishbone command registers
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "snp_regs.svh"
module snp_ctrl import snp_pkg::*; #(
  parameter int SCK_HALF = 4,  // clk cycles per half serial clock
  parameter int DEPTH = 2176   // page buffer bytes
) (
  input wire logic clk_i,             // 250 MHz clock
  input wire logic rst_i,             // sync reset, active high
  input wire logic wb_cyc_i,          // wishbone cycle
  input wire logic wb_stb_i,          // wishbone strobe
  input wire logic wb_we_i,           // wishbone write
  input wire logic [7:0] wb_adr_i,    // byte address
  input wire logic [3:0] wb_sel_i,    // byte enables
  input wire logic [31:0] wb_dat_i,   // write data
  output logic [31:0] wb_dat_o,       // read data
  output logic wb_ack_o,              // acknowledge
  output logic cs_n_o,                // chip select, active low
  output logic sclk_o,                // serial clock
  output logic [3:0] io_o,            // serial lines out
  output logic [3:0] io_oe_n_o,       // serial lines enable, low drives
  input wire logic [3:0] io_i         // serial lines in
);
  localparam int AW = 12;
  initial begin
    if (SCK_HALF < 3) $error("snp_ctrl: SCK_HALF below 3");
    if (DEPTH < 2176 || DEPTH > 4096) $error("snp_ctrl: bad DEPTH");
  end

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction : merge

  function automatic logic pair_ok(input logic [23:0] a, input logic [23:0] b);
    return (a[`SNP_BLK_LSB] == b[`SNP_BLK_LSB]) && (a[`SNP_BLK_MSB] == b[`SNP_BLK_MSB]);
  endfunction : pair_ok

  // ==========================================
  // registers and wishbone slave
  logic [23:0] row;
  logic [11:0] col, len, wptr;
  logic qie, ecc;
  logic [31:0] stat_word;
  logic wb_req, ctrl_wr;
  snp_buf_if #(.AW(AW)) bif ();
  snp_buf #(.DEPTH(DEPTH), .AW(AW)) u_buf (.clk_i(clk_i), .bus(bif));

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrl_wr = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SNP_OFS_CTRL;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SNP_OFS_ROW: wb_dat_o <= {8'h0, row};
          `SNP_OFS_COL: wb_dat_o <= {4'h0, len, 4'h0, col};
          `SNP_OFS_STAT: wb_dat_o <= stat_word;
          `SNP_OFS_FEAT: wb_dat_o <= {30'h0, ecc, qie};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row <= `SNP_ROW_RST;
      col <= `SNP_COL_RST;
      len <= 12'h000;
      wptr <= 12'h000;
      qie <= 1'b0;
      ecc <= 1'b0;
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        `SNP_OFS_ROW: row <= 24'(merge({8'h0, row}, wb_dat_i, wb_sel_i));
        `SNP_OFS_COL: begin
          col <= 12'(merge({20'h0, col}, wb_dat_i, wb_sel_i));
          len <= 12'(merge({4'h0, len, 16'h0}, wb_dat_i, wb_sel_i) >> 16);
          wptr <= 12'(merge({20'h0, col}, wb_dat_i, wb_sel_i));
        end
        `SNP_OFS_DATA: if (wb_sel_i[0]) wptr <= wptr + 12'h001;
        `SNP_OFS_FEAT: if (wb_sel_i[0]) begin
          qie <= wb_dat_i[`SNP_FEAT_QIE];
          ecc <= wb_dat_i[`SNP_FEAT_ECC];
        end
        default: ;
      endcase
    end
  end

  assign bif.we = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SNP_OFS_DATA;
  assign bif.waddr = wptr;
  assign bif.wdata = wb_dat_i[7:0];

  // ==========================================
  // command sequencer
  snp_seq_e q_st;
  snp_cmd_e cur, req;
  logic start, e_done, moving, dev_qie, dev_ecc;
  logic err_busy, err_quad, err_len, err_pair, pfail, efail;
  logic [23:0] src_row;
  logic [7:0] dev_stat, rbyte;
  logic [12:0] limit, span;
  logic is_load, is_quad, need_wren, need_poll, bad;

  assign req = snp_cmd_e'(wb_dat_i[3:0]);
  assign is_load = req inside {CMD_LOAD, CMD_LOAD4, CMD_RAND, CMD_RAND4};
  assign is_quad = req inside {CMD_LOAD4, CMD_RAND4};
  // limit follows the ecc state last sent by set feature
  assign limit = dev_ecc ? `SNP_MAX_ECC : `SNP_MAX_NOECC;
  assign span = {1'b0, col} + {1'b0, len};
  assign need_wren = cur inside {CMD_EXEC, CMD_EXEC_BG, CMD_ERASE};
  assign need_poll = cur inside {CMD_EXEC, CMD_EXEC_BG, CMD_ERASE, CMD_PAGE_RD};
  assign bad = (is_quad && !dev_qie) || (is_load && span > limit)
             || (req inside {CMD_EXEC, CMD_EXEC_BG} && moving && !pair_ok(src_row, row));
  assign stat_word = {16'h0, dev_stat, pfail, efail, err_pair, err_len, err_quad,
                      err_busy, 1'b0, q_st != Q_IDLE};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_st <= Q_IDLE;
      cur <= CMD_NONE;
      start <= 1'b0;
      {err_busy, err_quad, err_len, err_pair, pfail, efail} <= 6'h00;
    end else begin
      start <= 1'b0;
      case (q_st)
        Q_IDLE: if (ctrl_wr && req != CMD_NONE) begin
          err_quad <= is_quad && !dev_qie;
          err_len <= is_load && span > limit;
          // refuse bad block pairing for a move
          err_pair <= req inside {CMD_EXEC, CMD_EXEC_BG} && moving && !pair_ok(src_row, row);
          err_busy <= 1'b0;
          if (!bad) begin
            cur <= req;
            start <= 1'b1;
            q_st <= req inside {CMD_EXEC, CMD_EXEC_BG, CMD_ERASE} ? Q_WREN : Q_MAIN;
          end
        end
        Q_WREN: if (e_done) begin
          q_st <= Q_MAIN;
          start <= 1'b1;
        end
        Q_MAIN: if (e_done) begin
          q_st <= need_poll ? Q_POLL : Q_IDLE;
          start <= need_poll;
        end
        Q_POLL: if (e_done) begin
          if (cur == CMD_EXEC_BG ? rbyte[`SNP_ST2_CBUSY] : rbyte[`SNP_ST_BUSY]) begin
            start <= 1'b1;
          end else begin
            q_st <= Q_IDLE;
          end
          // report fail bits from final status, except after background execute
          if (cur != CMD_EXEC_BG) begin
            pfail <= rbyte[`SNP_ST_PFAIL];
            efail <= rbyte[`SNP_ST_EFAIL];
          end
        end
        default: q_st <= Q_IDLE;
      endcase
      if (ctrl_wr && q_st != Q_IDLE) err_busy <= 1'b1;
    end
  end

  // device-side state the host tracks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      moving <= 1'b0;
      src_row <= 24'h0;
      dev_qie <= 1'b0;
      dev_ecc <= 1'b0;
      dev_stat <= 8'h00;
    end else if (q_st == Q_MAIN && e_done) begin
      case (cur)
        CMD_PAGE_RD: begin
          // page read opens a data move
          moving <= 1'b1;
          src_row <= row;
        end
        CMD_LOAD, CMD_LOAD4, CMD_EXEC, CMD_EXEC_BG, CMD_ERASE: moving <= 1'b0;
        CMD_SET_FEAT: begin
          dev_qie <= qie;
          dev_ecc <= ecc;
        end
        CMD_GET_STAT: dev_stat <= rbyte;
        default: ;
      endcase
    end else if (q_st == Q_POLL && e_done) begin
      dev_stat <= rbyte;
    end
  end

  // ==========================================
  // frame descriptor
  logic [7:0] d_opc;
  logic [2:0] d_nadr;
  logic [31:0] d_adr;
  logic [11:0] d_ndat;
  logic d_quad, d_rd;
  always_comb begin
    d_opc = `SNP_OP_WRITE_EN;
    d_nadr = 3'd0;
    d_adr = 32'h0;
    d_ndat = 12'h000;
    d_quad = 1'b0;
    d_rd = 1'b0;
    if (q_st == Q_POLL || (q_st == Q_MAIN && cur == CMD_GET_STAT)) begin
      d_opc = `SNP_OP_GET_FEAT;
      d_nadr = 3'd1;
      d_adr = {24'h0, q_st == Q_POLL && cur == CMD_EXEC_BG ? `SNP_FA_STAT2 : `SNP_FA_STAT};
      d_rd = 1'b1;
    end else if (q_st == Q_MAIN) begin
      d_nadr = 3'd3;
      d_adr = {8'h0, row};
      case (cur)
        CMD_LOAD, CMD_LOAD4, CMD_RAND, CMD_RAND4: begin
          d_opc = cur == CMD_LOAD ? `SNP_OP_LOAD : cur == CMD_LOAD4 ? `SNP_OP_LOAD4 :
                  cur == CMD_RAND ? `SNP_OP_RAND : `SNP_OP_RAND4;
          d_nadr = 3'd2;
          d_adr = {20'h0, col};
          d_ndat = len;
          d_quad = cur inside {CMD_LOAD4, CMD_RAND4};
        end
        // plain execute, also ends a cached run
        CMD_EXEC: d_opc = `SNP_OP_EXEC;
        // background execute carries the tail opcode
        CMD_EXEC_BG: begin
          d_opc = `SNP_OP_EXEC;
          d_nadr = 3'd4;
          d_adr = {row, `SNP_OP_BG_TAIL};
        end
        CMD_ERASE: d_opc = `SNP_OP_ERASE;
        CMD_PAGE_RD: d_opc = `SNP_OP_PAGE_RD;
        CMD_SET_FEAT: begin
          d_opc = `SNP_OP_SET_FEAT;
          d_nadr = 3'd2;
          d_adr = {16'h0, `SNP_FA_CFG, 3'b000, ecc, 3'b000, qie};
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // serial engine, mode 0
  snp_eng_e e_st;
  snp_seg_e seg;
  logic [7:0] sh;
  logic [2:0] bitn, acnt;
  logic [11:0] left, rptr;
  logic [31:0] adr;
  logic quad, rd;
  logic [3:0] io_s1, io_s2;
  logic [$clog2(SCK_HALF)-1:0] div;
  logic tick;

  // inputs come from the device's domain
  always_ff @(posedge clk_i) begin
    io_s1 <= io_i;
    io_s2 <= io_s1;
  end

  assign tick = div == ($clog2(SCK_HALF))'(SCK_HALF - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || e_st == E_IDLE || tick) div <= '0;
    else div <= div + 1'b1;
  end

  assign bif.raddr = rptr;
  // line 1 driven only while quad data is on the wire; lines 0, 2 and 3 always driven
  assign io_oe_n_o = {2'b00, !(quad && seg == SG_DAT && !cs_n_o), 1'b0};
  assign io_o = (quad && seg == SG_DAT && !cs_n_o) ? sh[7:4] : {3'b110, sh[7]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e_st <= E_IDLE;
      seg <= SG_OPC;
      cs_n_o <= 1'b1;
      sclk_o <= 1'b0;
      sh <= 8'h00;
      {bitn, acnt} <= 6'h00;
      {left, rptr} <= 24'h0;
      adr <= 32'h0;
      {quad, rd, e_done} <= 3'b000;
      rbyte <= 8'h00;
    end else begin
      e_done <= 1'b0;
      case (e_st)
        E_IDLE: if (start) begin
          {cs_n_o, sh, bitn} <= {1'b0, d_opc, 3'd7};
          seg <= SG_OPC;
          {acnt, adr, left, quad, rd} <= {d_nadr, d_adr, d_ndat, d_quad, d_rd};
          rptr <= col;
          e_st <= E_RUN;
        end
        E_RUN: if (tick) begin
          sclk_o <= !sclk_o;
          if (!sclk_o && seg == SG_RD) begin
            sh <= {sh[6:0], io_s2[1]};
          end else if (sclk_o && bitn != 3'd0) begin
            bitn <= bitn - 3'd1;
            if (seg != SG_RD) sh <= (quad && seg == SG_DAT) ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
          end else if (sclk_o) begin
            bitn <= 3'd7;
            if (seg == SG_RD) begin
              rbyte <= sh;
              e_st <= E_END;
            end else if (seg != SG_DAT && acnt != 3'd0) begin
              seg <= SG_ADR;
              acnt <= acnt - 3'd1;
              sh <= adr[8*(acnt-3'd1) +: 8];
            end else if (left != 12'h000) begin
              // data comes from the prefetched buffer word
              seg <= SG_DAT;
              sh <= bif.rdata;
              left <= left - 12'h001;
              rptr <= rptr + 12'h001;
              bitn <= quad ? 3'd1 : 3'd7;
            end else if (rd) begin
              seg <= SG_RD;
            end else begin
              e_st <= E_END;
            end
          end
        end
        // frame ends with chip select high
        E_END: if (tick) begin
          cs_n_o <= 1'b1;
          e_st <= E_GAP;
        end
        E_GAP: if (tick) begin
          e_st <= E_IDLE;
          e_done <= 1'b1;
        end
        default: e_st <= E_IDLE;
      endcase
    end
  end

  // ==========================================
  // checks
  a_cs_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_IDLE && !start |-> cs_n_o) else $error("frame open while idle");
  a_quad_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_MAIN && cur inside {CMD_LOAD4, CMD_RAND4} |-> dev_qie)
    else $error("quad load without enable");
  a_wren_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q_st == Q_MAIN) && need_wren |-> $past(q_st) == Q_WREN)
    else $error("array command without write enable");
  a_load_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_MAIN && cur inside {CMD_LOAD, CMD_LOAD4} |-> span <= limit)
    else $error("load exceeds page");
  a_move_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_WREN && moving && cur inside {CMD_EXEC, CMD_EXEC_BG} |-> pair_ok(src_row, row))
    else $error("bad move pairing");
  a_poll_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_MAIN && e_done && cur == CMD_ERASE |=> q_st == Q_POLL && start)
    else $error("no polling after erase");
  a_cbusy_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    q_st == Q_POLL && cur == CMD_EXEC_BG ##1 q_st == Q_IDLE |-> !$past(rbyte[1]))
    else $error("left polling while cache busy");
  a_sclk_rest: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_n_o |-> !sclk_o) else $error("serial clock toggles outside frame");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_busy_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && q_st != Q_IDLE |=> err_busy) else $error("busy write not refused");
endmodule : snp_ctrl

// >>> snp_dev_model.sv
// behavioural serial nand device seen by the sequencer
`timescale 1ns/1ps
module snp_dev_model (
  input wire logic cs_n_i, // chip select, active low
  input wire logic sclk_i, // serial clock
  input wire logic [3:0] io_i, // host line outputs
  input wire logic [3:0] oe_n_i, // host enables, low drives
  output logic [3:0] io_o // line levels seen by host
);
  logic [7:0] cache [0:4095];
  logic [7:0] feat = 8'h00, opc, b, t;
  logic [23:0] row, prog_row = 24'h0, ers_row = 24'h0;
  logic write_enable_latch = 1'b0, bg_seen = 1'b0, efail = 1'b0, pfail = 1'b0;
  logic fail_next = 1'b0;
  logic dout = 1'b0, dev_oe = 1'b0, stop, quad, qd, okr;
  int busy_left = 0, busy_polls = 1, kind = 0, col;
  // released line shows inverse of last bit, never a stale copy
  assign io_o = {io_i[3:2], dev_oe ? dout : (oe_n_i[1] ? ~dout : io_i[1]), io_i[0]};
  task automatic get_bits(input int n, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (!stop) @(posedge sclk_i or posedge cs_n_i);
      if (cs_n_i) stop = 1'b1;
      else v = quad ? {v[3:0], io_i} : {v[6:0], io_i[0]};
    end
  endtask : get_bits
  always begin
    @(negedge cs_n_i);
    stop = 1'b0;
    quad = 1'b0;
    get_bits(8, opc);
    // busy array takes status reads only, and plain loads during a cache program
    if (busy_left != 0 && opc != 8'h0F && !(kind == 3 && opc == 8'h02)) opc = 8'h00;
    case (opc)
      8'h06: if (!stop) write_enable_latch = 1'b1;
      8'h1F: begin
        get_bits(8, t);
        get_bits(8, b);
        if (!stop && t == 8'hB0) feat = b;
      end
      8'h0F: begin
        get_bits(8, t);
        if (t == 8'hC0) b = {4'h0, pfail, efail, write_enable_latch, busy_left != 0};
        else b = {6'h00, kind == 3 && busy_left != 0, 1'b0};
        dev_oe = 1'b1;
        for (int i = 7; i >= 0 && !cs_n_i; i--) begin
          @(negedge sclk_i or posedge cs_n_i);
          dout = b[i];
        end
        if (!cs_n_i) @(posedge cs_n_i);
        dev_oe = 1'b0;
        if (busy_left > 0) busy_left--;
        if (busy_left == 0 && kind != 0) begin
          pfail = kind != 2 && fail_next;
          efail = kind == 2 && fail_next;
          kind = 0;
        end
      end
      8'h02, 8'h32, 8'h84, 8'hC4, 8'h34: begin
        qd = opc == 8'h32 || opc == 8'hC4 || opc == 8'h34;
        if (!qd || feat[0]) begin
          if (opc == 8'h02 || opc == 8'h32) foreach (cache[i]) cache[i] = 8'hFF;
          get_bits(8, t);
          get_bits(8, b);
          col = {t[3:0], b};
          quad = qd;
          while (!stop) begin
            get_bits(quad ? 2 : 8, b);
            if (!stop && col < (feat[4] ? 2112 : 2176)) cache[col] = b;
            col++;
          end
        end
      end
      8'h10, 8'hD8: begin
        for (int i = 0; i < 3; i++) begin
          get_bits(8, b);
          row = {row[15:0], b};
        end
        okr = !stop;
        get_bits(8, t);
        if (okr && write_enable_latch) begin
          write_enable_latch = 1'b0;
          busy_left = busy_polls;
          bg_seen = opc == 8'h10 && !stop && t == 8'h15;
          kind = opc == 8'hD8 ? 2 : (bg_seen ? 3 : 1);
          if (opc == 8'hD8) ers_row = row;
          else prog_row = row;
        end
      end
      default: ;
    endcase
  end
endmodule : snp_dev_model

// >>> tb_spi_nand_program_erase.sv
// self-checking bench for the nand program/erase sequencer
`timescale 1ns/1ps
`include "snp_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_spi_nand_program_erase;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic wb_ack, cs_n, sclk;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF, io_o, io_oe_n, io_i;
  logic [31:0] wb_dat = 32'h0, wb_rdat, q;
  int errors = 0, n_compared = 0, cyc_cnt = 0;
  logic [23:0] mv_dst [3] = '{24'h000080, 24'h020040, 24'h0000C0};
  logic [7:0] mv_st [3] = '{8'h20, 8'h20, 8'h00};
  snp_ctrl #(.SCK_HALF(4), .DEPTH(2176)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io_o), .io_oe_n_o(io_oe_n),
    .io_i(io_i)
  );
  snp_dev_model i_dev (
    .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_o), .oe_n_i(io_oe_n), .io_o(io_i)
  );
  always #2 clk_i = ~clk_i;
  // ==========================================
  // hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================
  // bus access
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask : wr
  task automatic st_chk(input logic [7:0] e);
    wb_xfer(1'b0, `SNP_OFS_STAT, 32'h0);
    `CHK("status", e, q[7:0])
  endtask : st_chk
  // poll status; a command refused while idle never shows busy
  task automatic run(input logic [3:0] c);
    wr(`SNP_OFS_CTRL, {28'h0, c});
    do wb_xfer(1'b0, `SNP_OFS_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask : run
  task automatic exe(input logic [23:0] r, input logic [3:0] c);
    wr(`SNP_OFS_ROW, {8'h00, r});
    run(c);
  endtask : exe
  task automatic cmd(input logic [31:0] colw, input logic [3:0] c, input logic [7:0] e);
    wr(`SNP_OFS_COL, colw);
    run(c);
    st_chk(e);
  endtask : cmd
  task automatic feat_set(input logic [1:0] v);
    wr(`SNP_OFS_FEAT, {30'h0, v});
    run(4'h9);
    `CHK("feature", {3'b000, v[1], 3'b000, v[0]}, i_dev.feat)
  endtask : feat_set
  task automatic load(input logic [31:0] colw, input logic [7:0] d0, input int n,
                      input logic [3:0] c);
    wr(`SNP_OFS_COL, colw);
    for (int i = 0; i < n; i++) wr(`SNP_OFS_DATA, {24'h0, d0 + 8'(i * 17)});
    run(c);
    for (int i = 0; i < n; i++) `CHK("cache", d0 + 8'(i * 17), i_dev.cache[colw[11:0] + i])
  endtask : load
  // ==========================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("idle pins", 10'b1_0_0010_1100, {cs_n, sclk, io_oe_n, io_o})
    wb_xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    st_chk(8'h00);
    feat_set(2'b00);
    cmd(32'h0002_0000, 4'h2, 8'h08);
    cmd(32'h0881_0000, 4'h1, 8'h10);
    feat_set(2'b10);
    cmd(32'h0841_0000, 4'h1, 8'h10);
    i_dev.cache[9] = 8'h00;
    load(32'h0003_0005, 8'hA1, 3, 4'h1);
    `CHK("unloaded", 8'hFF, i_dev.cache[9])
    load(32'h0001_0006, 8'h5A, 1, 4'h3);
    `CHK("kept", 8'hC3, i_dev.cache[7])
    exe(24'h012345, 4'h5);
    `CHK("prog row", 24'h012345, i_dev.prog_row)
    `CHK("latch", 1'b0, i_dev.write_enable_latch)
    st_chk(8'h00);
    i_dev.fail_next = 1'b1;
    exe(24'h012346, 4'h5);
    st_chk(8'h80);
    i_dev.fail_next = 1'b0;
    feat_set(2'b01);
    load(32'h0002_0010, 8'h3C, 2, 4'h2);
    load(32'h0001_0011, 8'hE7, 1, 4'h4);
    `CHK("quad kept", 8'h3C, i_dev.cache[16])
    load(32'h0001_0030, 8'h99, 1, 4'h3);
    `CHK("gap kept", 8'hE7, i_dev.cache[17])
    i_dev.busy_polls = 2;
    exe(24'h000841, 4'h6);
    `CHK("bg tail", 1'b1, i_dev.bg_seen)
    exe(24'h000880, 4'h6);
    `CHK("bg row", 24'h000880, i_dev.prog_row)
    exe(24'h0008BF, 4'h5);
    `CHK("last plain", 1'b0, i_dev.bg_seen)
    i_dev.efail = 1'b1;
    run(4'hA);
    st_chk(8'h00);
    `CHK("device status", 8'h04, q[15:8])
    i_dev.busy_polls = 4;
    exe(24'h000FC0, 4'h7);
    `CHK("erase row", 24'h000FC0, i_dev.ers_row)
    st_chk(8'h00);
    i_dev.fail_next = 1'b1;
    exe(24'h000F80, 4'h7);
    st_chk(8'h40);
    i_dev.fail_next = 1'b0;
    i_dev.busy_polls = 10;
    wr(`SNP_OFS_ROW, 32'h0000_1000);
    wr(`SNP_OFS_CTRL, 32'h0000_0007);
    run(4'h1);
    st_chk(8'h04);
    `CHK("erase row", 24'h001000, i_dev.ers_row)
    i_dev.busy_polls = 1;
    for (int i = 0; i < 3; i++) begin
      exe(24'h000040, 4'h8);
      exe(mv_dst[i], 4'h5);
      st_chk(mv_st[i]);
    end
    `CHK("moved row", 24'h0000C0, i_dev.prog_row)
    finish_test();
  end
endmodule : tb_spi_nand_program_erase
